// *** smcsr_pkg.sv ***
package smcsr_pkg;

	// Configuration-space offsets of the registers held here
	localparam logic [11:0] OFF_CPL_EN         = 12'h350;
	localparam logic [11:0] OFF_CPL_THR_NARROW = 12'h354;
	localparam logic [11:0] OFF_CPL_THR_WIDE   = 12'h358;
	localparam logic [11:0] OFF_PWR_SAVE       = 12'h360;
	localparam logic [11:0] OFF_LED            = 12'h364;
	localparam logic [11:0] OFF_OP_MODE        = 12'h098;
	localparam logic [11:0] OFF_L23_CTRL       = 12'h09C;

	// Function number of the upstream port; downstream port k is function k
	localparam logic [1:0]  FUNC_UP            = 2'h0;

	// Completion flow control: enable bit of port k sits at bit k
	localparam int          CPL_EN_LSB         = 1;
	localparam logic [15:0] THR_X1_RST         = 16'h0080;
	localparam logic [15:0] THR_X2_RST         = 16'h0200;
	localparam logic [15:0] THR_X4_RST         = 16'h0800;

	// Clock buffer control field in the operation mode register
	localparam int          CLKBUF_CTL_LSB     = 16;
	localparam int          NUM_REF_OUT        = 7;
	localparam logic [7:0]  CLKBUF_CTL_RST     = 8'h00;

	// Power saving disable and LED fields
	localparam int          PWR_SAVE_BIT       = 0;
	localparam int          LED_WIDTH          = 7;

	// Device-specific L2/L3 control and status bits
	localparam int          L23_TURNOFF_BIT    = 0;
	localparam int          L23_CUT_BIT        = 1;
	localparam int          L23_RESTORE_BIT    = 2;
	localparam int          L23_ST_ACK_BIT     = 8;
	localparam int          L23_ST_OFF_BIT     = 9;
	localparam int          L23_ST_RST_BIT     = 10;

	// Timing of the dedicated reset after power returns
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          RST_HOLD_NS        = 1000;
	localparam int          RST_HOLD_CYC       = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		LW_X1,
		LW_X2,
		LW_X4
	} smcsr_width_e;

	typedef struct packed {
		logic       mode;
		logic       enable;
		logic [4:0] sel;
	} smcsr_led_s;

	typedef struct packed {
		logic [15:0] x2;
		logic [15:0] x1;
	} smcsr_thr_s;

	typedef enum {
		L23_ACTIVE,
		L23_SEND,
		L23_WAIT_ACK,
		L23_ACKED,
		L23_OFF,
		L23_RESET
	} smcsr_l23_e;

	// Byte-lane merge of a configuration write
	function automatic logic [31:0] smcsr_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// *** smcsr_l23_seq.sv ***
`timescale 1ns/1ps
module smcsr_l23_seq
	import smcsr_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic turnoff_req_i,
	input  wire logic cut_req_i,
	input  wire logic restore_req_i,
	input  wire logic ack_i,
	output logic      pme_turnoff_o,
	output logic      power_en_o,
	output logic      dev_reset_o,
	output logic      acked_o
);

	localparam int CW       = $clog2(RST_HOLD_CYC + 1);
	localparam int RST_LAST = RST_HOLD_CYC - 1;

	smcsr_l23_e    state_reg, state_next;
	logic [CW-1:0] cnt_reg,   cnt_next;

	// Requests outside their state are ignored, so a stray write cannot cut live power
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			L23_ACTIVE:   if (turnoff_req_i) state_next = L23_SEND;
			L23_SEND:     state_next = L23_WAIT_ACK;
			L23_WAIT_ACK: if (ack_i) state_next = L23_ACKED;
			L23_ACKED:    if (cut_req_i) state_next = L23_OFF;
			L23_OFF: begin
				if (restore_req_i) begin
					state_next = L23_RESET;
					cnt_next   = CW'(RST_HOLD_CYC);
				end
			end
			L23_RESET: begin
				if (cnt_reg == CW'(1)) begin
					state_next = L23_ACTIVE;
				end
				cnt_next = cnt_reg - CW'(1);
			end
			default:      state_next = L23_ACTIVE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= L23_ACTIVE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Message goes only to this port's device
	assign pme_turnoff_o = (state_reg == L23_SEND);
	assign power_en_o    = (state_reg != L23_OFF);
	assign dev_reset_o   = (state_reg == L23_RESET);
	assign acked_o       = (state_reg == L23_ACKED) || (state_reg == L23_OFF);

	power_after_ack_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(power_en_o) |-> $past(acked_o) && $past(cut_req_i))
		else $error("Power cut without prior acknowledge");
	reset_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(dev_reset_o) |-> ##RST_LAST dev_reset_o ##1 !dev_reset_o)
		else $error("Dedicated reset length wrong");
	turnoff_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
		pme_turnoff_o |=> !pme_turnoff_o && power_en_o)
		else $error("Turn-off message not a single pulse");

endmodule // smcsr_l23_seq

// *** smcsr_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Port 1 completion flow control acts only when its enable bit is set; reset 0.
// - Port 2 completion flow control acts only when its enable bit is set; reset 0.
// - Single-lane threshold, low half of its register, resets to 0x0080.
// - Two-lane threshold, upper half of that register, resets to 0x0200.
// - Four-lane threshold, low half of next register, upper half reserved, reset 0x0800.
// - Flow control enable and thresholds exist only in upstream configuration space.
// - Power saving suppressed while disable bit set; reset 0, sideband may preload.
// - Upstream LED register: mode select 4:0, enable bit 5, mode bit 6, reset 0.
// - Reference clock buffer enabled when power-down strap sampled low.
// - Enabled buffer fans one 100 MHz input out to seven output pairs 7..1.
// - Strap high disables all output pairs; core reference comes from core input.
// - Bits 23:16 of operation mode register, sideband loaded; bits 23:17 disable single pairs 7..1.
// - Each downstream port sends its own turn-off message to its device alone.
// - Exit: software restores power, then dedicated reset; entry: cut after acknowledge.
// - The L2/L3 control register exists only in downstream ports.
// - D0-D3cold and L0, L0s, L1, L2/L3, L3 with active-state link PM supported.
// - Latency tolerance reporting and buffer flush/fill aligned with root complex.
module smcsr_top
	import smcsr_pkg::*;
#(
	parameter int NUM_DS = 2
)(
	input  wire logic                           SYS_CLK_I,
	input  wire logic                           RESET_I,
	input  wire logic [1:0]                     CFG_FUNC_I,
	input  wire logic                           CFG_WR_I,
	input  wire logic                           CFG_RD_I,
	input  wire logic [11:0]                    CFG_ADDR_I,
	input  wire logic [3:0]                     CFG_BE_I,
	input  wire logic [31:0]                    CFG_WDATA_I,
	output logic      [31:0]                    CFG_RDATA_O,
	output logic                                CFG_RVALID_O,
	input  wire logic                           SB_WR_I,
	input  wire logic [11:0]                    SB_ADDR_I,
	input  wire logic [31:0]                    SB_WDATA_I,
	input  wire logic                           CLOCK_BUFFER_POWERDOWN_STRAP_I,
	input  wire logic                           BUFFER_REF_IN_POS_I,
	input  wire logic                           BUFFER_REF_IN_NEG_I,
	input  wire logic                           CORE_REF_IN_POS_I,
	input  wire logic                           CORE_REF_IN_NEG_I,
	output logic      [NUM_REF_OUT:1]           BUFFERED_REF_OUT_POS_O,
	output logic      [NUM_REF_OUT:1]           BUFFERED_REF_OUT_NEG_O,
	output logic      [NUM_REF_OUT:1]           REF_OUT_EN_O,
	output logic                                CORE_REF_POS_O,
	output logic                                CORE_REF_NEG_O,
	input  wire smcsr_width_e [NUM_DS:1]        LINK_WIDTH_I,
	output logic      [NUM_DS:1]                CPL_FC_EN_O,
	output logic      [NUM_DS:1][15:0]          CPL_FC_THRESH_O,
	output logic                                POWER_SAVE_DISABLE_O,
	output logic                                ASPM_ALLOW_O,
	output logic                                LTR_OBFF_ALLOW_O,
	output smcsr_led_s                          LED_CTRL_O,
	output logic      [NUM_DS:1]                PME_TURNOFF_O,
	input  wire logic [NUM_DS:1]                PME_TURNOFF_ACK_I,
	output logic      [NUM_DS:1]                DEV_POWER_EN_O,
	output logic      [NUM_DS:1]                DEV_RESET_O
);

	if (NUM_DS < 1 || NUM_DS > 2) begin : g_bad_ds
		$error("NUM_DS must be 1 or 2");
	end

	// Register state
	logic [NUM_DS:1] cpl_en_reg,   cpl_en_next;
	smcsr_thr_s      thr_n_reg,    thr_n_next;
	logic [15:0]     thr_x4_reg,   thr_x4_next;
	logic            pwr_dis_reg,  pwr_dis_next;
	smcsr_led_s      led_reg,      led_next;
	logic [7:0]      cb_ctl_reg,   cb_ctl_next;
	logic            strap_reg,    strap_next;
	logic            strap_done_reg, strap_done_next;
	logic [31:0]     rdata_reg,    rdata_next;
	logic            rvalid_reg,   rvalid_next;
	logic [NUM_DS:1][15:0] thr_reg, thr_next;

	logic            cfg_up;
	logic            cfg_up_wr;
	logic [NUM_DS:1] l23_turnoff, l23_cut, l23_restore, l23_acked;

	// Upstream-only registers answer only to the upstream function
	assign cfg_up    = (CFG_FUNC_I == FUNC_UP);
	assign cfg_up_wr = CFG_WR_I && cfg_up;

	// Writes: configuration first, sideband preload last so it wins a same-cycle clash
	always_comb begin
		logic [31:0] w;
		w            = '0;
		cpl_en_next  = cpl_en_reg;
		thr_n_next   = thr_n_reg;
		thr_x4_next  = thr_x4_reg;
		pwr_dis_next = pwr_dis_reg;
		led_next     = led_reg;
		cb_ctl_next  = cb_ctl_reg;
		if (cfg_up_wr) begin
			w = smcsr_merge('0, CFG_WDATA_I, CFG_BE_I);
			case (CFG_ADDR_I)
				OFF_CPL_EN: begin
					w = smcsr_merge(32'(cpl_en_reg) << CPL_EN_LSB, CFG_WDATA_I, CFG_BE_I);
					cpl_en_next = w[CPL_EN_LSB +: NUM_DS];
				end
				OFF_CPL_THR_NARROW: thr_n_next = smcsr_merge(thr_n_reg, CFG_WDATA_I, CFG_BE_I);
				OFF_CPL_THR_WIDE: begin
					w = smcsr_merge({16'h0000, thr_x4_reg}, CFG_WDATA_I, CFG_BE_I);
					thr_x4_next = w[15:0];
				end
				OFF_LED: begin
					w = smcsr_merge({25'h0, led_reg}, CFG_WDATA_I, CFG_BE_I);
					led_next = w[LED_WIDTH-1:0];
				end
				default: ;
			endcase
		end
		if (CFG_WR_I && CFG_ADDR_I == OFF_PWR_SAVE && CFG_BE_I[0]) begin
			pwr_dis_next = CFG_WDATA_I[PWR_SAVE_BIT];
		end
		if (SB_WR_I) begin
			case (SB_ADDR_I)
				OFF_PWR_SAVE:       pwr_dis_next = SB_WDATA_I[PWR_SAVE_BIT];
				OFF_OP_MODE:        cb_ctl_next  = SB_WDATA_I[CLKBUF_CTL_LSB +: 8];
				OFF_CPL_EN:         cpl_en_next  = SB_WDATA_I[CPL_EN_LSB +: NUM_DS];
				OFF_CPL_THR_NARROW: thr_n_next   = SB_WDATA_I;
				OFF_CPL_THR_WIDE:   thr_x4_next  = SB_WDATA_I[15:0];
				OFF_LED:            led_next     = SB_WDATA_I[LED_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// Strap is caught by a clocked sample in the first cycle after reset release
	always_comb begin
		strap_next      = strap_reg;
		strap_done_next = 1'b1;
		if (!strap_done_reg) begin
			strap_next = CLOCK_BUFFER_POWERDOWN_STRAP_I;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			cpl_en_reg     <= '0;
			thr_n_reg      <= '{x2: THR_X2_RST, x1: THR_X1_RST};
			thr_x4_reg     <= THR_X4_RST;
			pwr_dis_reg    <= 1'b0;
			led_reg        <= '0;
			cb_ctl_reg     <= CLKBUF_CTL_RST;
			strap_reg      <= 1'b1;
			strap_done_reg <= 1'b0;
		end else begin
			cpl_en_reg     <= cpl_en_next;
			thr_n_reg      <= thr_n_next;
			thr_x4_reg     <= thr_x4_next;
			pwr_dis_reg    <= pwr_dis_next;
			led_reg        <= led_next;
			cb_ctl_reg     <= cb_ctl_next;
			strap_reg      <= strap_next;
			strap_done_reg <= strap_done_next;
		end
	end

	// Read mux; unmapped or wrong-function reads give zero
	always_comb begin
		rdata_next  = '0;
		rvalid_next = CFG_RD_I;
		if (CFG_RD_I) begin
			case (CFG_ADDR_I)
				OFF_CPL_EN:         if (cfg_up) rdata_next = 32'(cpl_en_reg) << CPL_EN_LSB;
				OFF_CPL_THR_NARROW: if (cfg_up) rdata_next = thr_n_reg;
				OFF_CPL_THR_WIDE:   if (cfg_up) rdata_next = {16'h0000, thr_x4_reg};
				OFF_PWR_SAVE:       rdata_next = {31'h0, pwr_dis_reg};
				OFF_LED:            if (cfg_up) rdata_next = {25'h0, led_reg};
				OFF_OP_MODE:        rdata_next = {8'h00, cb_ctl_reg, 16'h0000};
				OFF_L23_CTRL: begin
					for (int k = 1; k <= NUM_DS; k++) begin
						if (CFG_FUNC_I == 2'(k)) begin
							rdata_next[L23_ST_ACK_BIT] = l23_acked[k];
							rdata_next[L23_ST_OFF_BIT] = !DEV_POWER_EN_O[k];
							rdata_next[L23_ST_RST_BIT] = DEV_RESET_O[k];
						end
					end
				end
				default: rdata_next = '0;
			endcase
		end
	end

	// Per-port threshold picked by trained link width
	always_comb begin
		for (int k = 1; k <= NUM_DS; k++) begin
			case (LINK_WIDTH_I[k])
				LW_X1:   thr_next[k] = thr_n_reg.x1;
				LW_X2:   thr_next[k] = thr_n_reg.x2;
				default: thr_next[k] = thr_x4_reg;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			rdata_reg  <= '0;
			rvalid_reg <= 1'b0;
			thr_reg    <= '0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
			thr_reg    <= thr_next;
		end
	end

	assign CFG_RDATA_O     = rdata_reg;
	assign CFG_RVALID_O    = rvalid_reg;
	assign CPL_FC_EN_O     = cpl_en_reg;
	assign CPL_FC_THRESH_O = thr_reg;

	// Power saving gates link PM and platform PM alike
	assign POWER_SAVE_DISABLE_O = pwr_dis_reg;
	assign ASPM_ALLOW_O         = !pwr_dis_reg;
	assign LTR_OBFF_ALLOW_O     = !pwr_dis_reg;
	assign LED_CTRL_O           = led_reg;

	// Clock buffer: pure gating of the reference, no retiming of the clock itself
	assign CORE_REF_POS_O = strap_reg ? CORE_REF_IN_POS_I : BUFFER_REF_IN_POS_I;
	assign CORE_REF_NEG_O = strap_reg ? CORE_REF_IN_NEG_I : BUFFER_REF_IN_NEG_I;
	for (genvar p = 1; p <= NUM_REF_OUT; p++) begin : g_refout
		assign REF_OUT_EN_O[p] = !strap_reg && !cb_ctl_reg[p];
		assign BUFFERED_REF_OUT_POS_O[p] = REF_OUT_EN_O[p] & BUFFER_REF_IN_POS_I;
		assign BUFFERED_REF_OUT_NEG_O[p] = REF_OUT_EN_O[p] & BUFFER_REF_IN_NEG_I;
	end

	// One L2/L3 sequencer per downstream port, commanded only from its own function
	for (genvar k = 1; k <= NUM_DS; k++) begin : g_ds
		logic hit;
		assign hit = CFG_WR_I && CFG_FUNC_I == 2'(k) && CFG_ADDR_I == OFF_L23_CTRL
			&& CFG_BE_I[0];
		assign l23_turnoff[k] = hit && CFG_WDATA_I[L23_TURNOFF_BIT];
		assign l23_cut[k]     = hit && CFG_WDATA_I[L23_CUT_BIT];
		assign l23_restore[k] = hit && CFG_WDATA_I[L23_RESTORE_BIT];
		smcsr_l23_seq u_seq (
			.clk_i         (SYS_CLK_I),
			.reset_i       (RESET_I),
			.turnoff_req_i (l23_turnoff[k]),
			.cut_req_i     (l23_cut[k]),
			.restore_req_i (l23_restore[k]),
			.ack_i         (PME_TURNOFF_ACK_I[k]),
			.pme_turnoff_o (PME_TURNOFF_O[k]),
			.power_en_o    (DEV_POWER_EN_O[k]),
			.dev_reset_o   (DEV_RESET_O[k]),
			.acked_o       (l23_acked[k])
		);
	end

	cpl_en_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		CFG_WR_I && !cfg_up && !SB_WR_I |=> $stable(CPL_FC_EN_O))
		else $error("Downstream write changed flow control enable");
	cpl_en_write_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		cfg_up_wr && CFG_ADDR_I == OFF_CPL_EN && CFG_BE_I[0] && !SB_WR_I
		|=> CPL_FC_EN_O == $past(CFG_WDATA_I[CPL_EN_LSB +: NUM_DS]))
		else $error("Flow control enable not written");
	thr_x1_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		LINK_WIDTH_I[1] == LW_X1 |=> CPL_FC_THRESH_O[1] == $past(thr_n_reg.x1))
		else $error("Single-lane threshold not selected");
	wide_rsvd_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		CFG_RD_I && CFG_ADDR_I == OFF_CPL_THR_WIDE |=> CFG_RVALID_O && CFG_RDATA_O[31:16] == 16'h0000)
		else $error("Reserved threshold half not zero");
	up_only_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		CFG_RD_I && !cfg_up && CFG_ADDR_I == OFF_CPL_THR_NARROW |=> CFG_RDATA_O == 32'h0000_0000)
		else $error("Threshold visible to downstream function");
	strap_off_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		strap_done_reg && strap_reg |-> REF_OUT_EN_O == '0)
		else $error("Reference outputs on while strap high");
	pair_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		SB_WR_I && SB_ADDR_I == OFF_OP_MODE && SB_WDATA_I[CLKBUF_CTL_LSB + 1]
		|=> !REF_OUT_EN_O[1])
		else $error("Disabled reference pair still on");
	pwr_save_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		POWER_SAVE_DISABLE_O |-> !ASPM_ALLOW_O && !LTR_OBFF_ALLOW_O)
		else $error("Power saving allowed while disabled");
	l23_up_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		CFG_WR_I && cfg_up && CFG_ADDR_I == OFF_L23_CTRL |=> (PME_TURNOFF_O == '0) [*2])
		else $error("Upstream write reached L2/L3 control");

endmodule // smcsr_top

// *** smcsr_ds_dev.sv ***
`timescale 1ns/1ps
// Downstream device model: answers a turn-off message after a set delay
module smcsr_ds_dev #(
	parameter int ACK_DELAY = 1
)(
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic pme_turnoff_i,
	input  wire logic power_en_i,
	output logic      ack_o
);
	int cnt_reg;
	// Count down from the pulse; an unpowered device never answers
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (reset_i || !power_en_i) begin
			cnt_reg <= 0;
		end else if (pme_turnoff_i) begin
			cnt_reg <= ACK_DELAY;
		end else if (cnt_reg > 0) begin
			cnt_reg <= cnt_reg - 1;
			ack_o   <= (cnt_reg == 1);
		end
	end
endmodule // smcsr_ds_dev

// *** switch_misc_csr_clock_pm_bench.sv ***
`timescale 1ns/1ps
module switch_misc_csr_clock_pm_bench;
	import smcsr_pkg::*;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic [1:0]            func = 2'h0;
	logic                  wr = 1'b0;
	logic                  rd_s = 1'b0;
	logic [11:0]           addr = 12'h000;
	logic [3:0]            be = 4'hF;
	logic [31:0]           wdata = 32'h0;
	logic [31:0]           rdata;
	logic                  rvalid;
	logic                  sb_wr = 1'b0;
	logic [11:0]           sb_addr = 12'h000;
	logic [31:0]           sb_data = 32'h0;
	logic                  strap = 1'b0;
	logic                  buf_p = 1'b1;
	logic                  buf_n = 1'b0;
	logic                  core_p = 1'b0;
	logic                  core_n = 1'b1;
	logic [7:1]            out_p;
	logic [7:1]            out_n;
	logic                  core_no;
	logic [7:1]            out_en;
	logic                  core_o;
	smcsr_width_e [2:1]    lw = '{LW_X4, LW_X1};
	logic [2:1]            fc_en;
	logic [2:1][15:0]      thr;
	logic                  ps_dis;
	logic                  aspm;
	logic                  ltr;
	smcsr_led_s            led;
	logic [2:1]            pme;
	logic [2:1]            ack;
	logic [2:1]            pwr;
	logic [2:1]            dres;
	logic [31:0]           rd;
	int                    fail_count = 0;
	int                    cmp_count = 0;
	int                    cycles = 0;
	int                    n;
	logic [11:0]           offs [5] = '{OFF_CPL_EN, OFF_CPL_THR_NARROW, OFF_CPL_THR_WIDE,
		OFF_PWR_SAVE, OFF_LED};
	logic [31:0]           rvals [5] = '{32'h0, {THR_X2_RST, THR_X1_RST},
		{16'h0, THR_X4_RST}, 32'h0, 32'h0};

	smcsr_top #(.NUM_DS(2)) uut (.SYS_CLK_I(clk), .RESET_I(rst), .CFG_FUNC_I(func),
		.CFG_WR_I(wr), .CFG_RD_I(rd_s), .CFG_ADDR_I(addr), .CFG_BE_I(be),
		.CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .SB_WR_I(sb_wr),
		.SB_ADDR_I(sb_addr), .SB_WDATA_I(sb_data), .CLOCK_BUFFER_POWERDOWN_STRAP_I(strap),
		.BUFFER_REF_IN_POS_I(buf_p), .BUFFER_REF_IN_NEG_I(buf_n), .CORE_REF_IN_POS_I(core_p),
		.CORE_REF_IN_NEG_I(core_n), .BUFFERED_REF_OUT_POS_O(out_p),
		.BUFFERED_REF_OUT_NEG_O(out_n), .REF_OUT_EN_O(out_en), .CORE_REF_POS_O(core_o),
		.CORE_REF_NEG_O(core_no), .LINK_WIDTH_I(lw), .CPL_FC_EN_O(fc_en),
		.CPL_FC_THRESH_O(thr),
		.POWER_SAVE_DISABLE_O(ps_dis), .ASPM_ALLOW_O(aspm), .LTR_OBFF_ALLOW_O(ltr),
		.LED_CTRL_O(led), .PME_TURNOFF_O(pme), .PME_TURNOFF_ACK_I(ack),
		.DEV_POWER_EN_O(pwr), .DEV_RESET_O(dres));

	// One prompt and one slow device on the two downstream ports
	smcsr_ds_dev #(.ACK_DELAY(1)) dev1 (.clk_i(clk), .reset_i(rst), .pme_turnoff_i(pme[1]),
		.power_en_i(pwr[1]), .ack_o(ack[1]));
	smcsr_ds_dev #(.ACK_DELAY(6)) dev2 (.clk_i(clk), .reset_i(rst), .pme_turnoff_i(pme[2]),
		.power_en_i(pwr[2]), .ack_o(ack[2]));

	// Clock generation
	always #5 clk = ~clk;

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs well under 3000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			$display("MISMATCH at %0t: run did not finish", $time);
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Strap is sampled just after release, so it is set while reset is held
	task automatic do_reset(input logic s);
		rst = 1'b1;
		strap = s;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic cfg_wr(input logic [1:0] f, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		func = f;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask

	task automatic cfg_rd(input logic [1:0] f, input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		#1;
		func = f;
		addr = a;
		rd_s = 1'b1;
		@(posedge clk);
		#1;
		rd_s = 1'b0;
		chk(32'(rvalid), 32'h1, "read valid");
		d = rdata;
	endtask

	task automatic sb_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		sb_addr = a;
		sb_data = d;
		sb_wr = 1'b1;
		@(posedge clk);
		#1;
		sb_wr = 1'b0;
	endtask

	// Poll the port status until the device's acknowledge shows
	task automatic wait_ack(input logic [1:0] p);
		n = 0;
		do begin
			cfg_rd(p, OFF_L23_CTRL, rd);
			n++;
		end while (rd[L23_ST_ACK_BIT] !== 1'b1 && n < 20);
	endtask

	initial begin
		do_reset(1'b0);
		for (int i = 0; i < 5; i++) begin
			cfg_rd(FUNC_UP, offs[i], rd);
			chk(rd, rvals[i], "reset value");
		end
		chk(32'(fc_en), 32'h0, "flow enable reset");
		chk(thr, {THR_X4_RST, THR_X1_RST}, "threshold select");
		chk(32'(led), 32'h0, "led reset");
		$display("Test reset values done");

		cfg_wr(FUNC_UP, OFF_CPL_EN, 32'hFFFF_FFFF);
		cfg_rd(FUNC_UP, OFF_CPL_EN, rd);
		chk(rd, 32'h6, "flow enable");
		chk(32'(fc_en), 32'h3, "flow enable out");
		cfg_wr(FUNC_UP, OFF_CPL_THR_NARROW, 32'h1234_5678);
		cfg_wr(FUNC_UP, OFF_CPL_THR_WIDE, 32'hFFFF_ABCD);
		cfg_rd(FUNC_UP, OFF_CPL_THR_WIDE, rd);
		chk(rd, 32'h0000_ABCD, "wide threshold");
		chk(thr, 32'hABCD_5678, "threshold x1 x4");
		lw[2] = LW_X2;
		@(posedge clk);
		#1;
		chk(thr, 32'h1234_5678, "threshold x2");
		cfg_rd(2'h1, OFF_CPL_THR_NARROW, rd);
		chk(rd, 32'h0, "downstream read");
		cfg_wr(2'h2, OFF_CPL_EN, 32'h0);
		chk(32'(fc_en), 32'h3, "downstream write");
		$display("Test flow control done");

		cfg_wr(2'h1, OFF_PWR_SAVE, 32'hFFFF_FFFF);
		cfg_rd(FUNC_UP, OFF_PWR_SAVE, rd);
		chk(rd, 32'h1, "power save");
		chk({ps_dis, aspm, ltr}, 32'h4, "power save out");
		sb_write(OFF_PWR_SAVE, 32'h0);
		chk({ps_dis, aspm, ltr}, 32'h3, "sideband power save");
		cfg_wr(FUNC_UP, OFF_LED, 32'hFFFF_FFFF);
		cfg_rd(FUNC_UP, OFF_LED, rd);
		chk(rd, 32'h7F, "led");
		be = 4'hE;
		cfg_wr(FUNC_UP, OFF_LED, 32'h0);
		be = 4'hF;
		chk(32'(led), 32'h7F, "led lane");
		$display("Test power save and led done");

		chk(32'(out_en), 32'h7F, "buffer on");
		chk(32'(out_p), 32'h7F, "fan out");
		chk(32'(core_o), 32'h1, "core from buffer");
		chk(32'(core_no), 32'h0, "core neg from buffer");
		// Swap the input polarity so both legs of every pair are seen to follow it
		buf_p = 1'b0;
		buf_n = 1'b1;
		#1;
		chk(32'(out_n), 32'h7F, "fan out neg");
		chk(32'(out_p), 32'h0, "fan out follows");
		chk(32'(core_no), 32'h1, "core neg follows buffer");
		buf_p = 1'b1;
		buf_n = 1'b0;
		sb_write(OFF_OP_MODE, 32'h000A_0000);
		chk(32'(out_en), 32'h7A, "pair disable");
		chk(32'(out_p), 32'h7A, "gated pairs");
		cfg_wr(FUNC_UP, OFF_OP_MODE, 32'h0);
		chk(32'(out_en), 32'h7A, "config write refused");
		cfg_rd(FUNC_UP, OFF_OP_MODE, rd);
		chk(32'(rd[23:16]), 32'h0A, "field read");
		$display("Test clock buffer done");

		cfg_wr(FUNC_UP, OFF_L23_CTRL, 32'h1);
		chk(32'(pme), 32'h0, "upstream turnoff");
		cfg_rd(FUNC_UP, OFF_L23_CTRL, rd);
		chk(rd, 32'h0, "upstream status");
		cfg_wr(2'h1, OFF_L23_CTRL, 32'h2);
		chk(32'(pwr), 32'h3, "early cut");
		cfg_wr(2'h1, OFF_L23_CTRL, 32'h1);
		chk(32'(pme), 32'h1, "turnoff port 1");
		@(posedge clk);
		#1;
		chk(32'(pme), 32'h0, "turnoff pulse");
		wait_ack(2'h1);
		chk(32'(rd[L23_ST_ACK_BIT]), 32'h1, "ack port 1");
		cfg_wr(2'h1, OFF_L23_CTRL, 32'h2);
		chk(32'(pwr), 32'h2, "cut port 1");
		cfg_rd(2'h1, OFF_L23_CTRL, rd);
		chk(32'(rd[L23_ST_OFF_BIT]), 32'h1, "off status");
		cfg_wr(2'h1, OFF_L23_CTRL, 32'h4);
		chk({pwr, dres}, 32'hD, "restore and reset");
		n = 0;
		while (dres[1] === 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n, RST_HOLD_CYC, "reset length");
		cfg_wr(2'h2, OFF_L23_CTRL, 32'h1);
		chk(32'(pme), 32'h2, "turnoff port 2");
		wait_ack(2'h2);
		chk(32'(rd[L23_ST_ACK_BIT]), 32'h1, "slow ack");
		$display("Test link power done");

		do_reset(1'b1);
		chk(32'(out_en), 32'h0, "buffer off");
		chk(32'(core_o), 32'h0, "core from core input");
		chk(32'(core_no), 32'h1, "core neg from core input");
		buf_n = 1'b1;
		#1;
		chk(32'(out_n), 32'h0, "neg pairs off");
		$display("Test strap high done");
		print_verdict();
	end
endmodule // switch_misc_csr_clock_pm_bench
